// File: fpeg_guard.v
// Flash program and erase guard top level
//
// Functional notes
// - Programming only clears bits; AND new data into old byte.
// - Erase covers a 512-byte page, all bytes become 0xFF.
// - Hardware times software write and erase and debug device erase; CPU stalls until done. Debug write and page erase are untimed.
// - Unlock needs key 0xA5 then 0xF1, any spacing.
// - Wrong key order or value disables flash changes until reset.
// - Flash change attempted while locked disables until reset.
// - Every completed software write or erase returns state to locked.
// - Store-write enable steers external-move writes to flash; held until cleared.
// - Both enables plus unlock: external-move write erases the page.
// - Store-write only plus unlock: external-move write programs one byte.
// - External-move reads go to RAM; code-move reads read flash.
// - Lock byte complement gives locked page count from page zero.
// - Lock byte page locked when any lock byte bit is zero.
// - Unlocked code touching locked page causes flash fault reset.
// - Debug port prohibited operations are ignored, no reset.
// - Software erasing lock page faults; debug only if nothing locked.
// - Software programming the lock byte after it is latched causes flash fault reset.
// - Lock byte written by software acts only after reset.
// - Reserved area access faults for software, ignored for debug.
// - Debug full device erase clears all pages and locks.
// - Key register read shows lock state in low two bits.
// - Flash change beyond 0x1DFF causes flash fault reset.
// - Data byte of an erase trigger is ignored.
`timescale 1ns/100ps
`default_nettype none
`include "fpeg_consts.vh"
module fpeg_guard (
  input wire sys_clk_in,
  input wire rst_in,
  input wire key_write_in,
  input wire [7:0] key_data_in,
  output wire [7:0] flash_key_register_out,
  input wire store_write_enable_in,
  input wire store_erase_enable_in,
  input wire xmove_write_in,
  input wire xmove_read_in,
  input wire code_read_in,
  input wire [15:0] addr_in,
  input wire [7:0] wdata_in,
  input wire [12:0] exec_pc_in,
  input wire [7:0] lock_byte_in,
  input wire [7:0] flash_rdata_in,
  input wire dbg_write_in,
  input wire dbg_page_erase_in,
  input wire dbg_device_erase_in,
  input wire dbg_read_in,
  output reg dbg_ignored_out,
  output wire cpu_stall_out,
  output wire external_data_ram_select_out,
  output reg flash_rd_out,
  output reg flash_prog_out,
  output reg flash_erase_page_out,
  output reg flash_erase_all_out,
  output reg [12:0] flash_addr_out,
  output reg [7:0] flash_wdata_out,
  output reg flash_fault_reset_out,
  output reg flash_fault_reset_flag_out
);
  // ****************************************
  // Lock state and latched lock byte
  // ****************************************
  reg [1:0] key_state;
  reg [7:0] lock_eff;
  reg lock_taken;
  reg fault_seen;
  reg tmr_start;
  reg [18:0] tmr_count;
  reg op_pending;
  reg op_is_prog;
  wire tmr_busy;
  wire tmr_done;
  wire [7:0] locked_pages;
  wire any_locked;
  wire [3:0] tgt_page;
  wire [3:0] pc_page;
  wire [3:0] lock_page;
  wire tgt_locked;
  wire pc_locked;
  wire above_user;
  wire access_bad;
  wire cpu_flash_wr;
  wire [12:0] lock_addr;
  wire [31:0] erase_cycles;
  wire [31:0] write_cycles;
  assign lock_addr = `FPEG_LOCK_ADDR;
  assign erase_cycles = `FPEG_ERASE_CYCLES;
  assign write_cycles = `FPEG_WRITE_CYCLES;
  assign flash_key_register_out = {6'h00, key_state};
  assign locked_pages = ~lock_eff;
  assign any_locked = (lock_eff != 8'hFF);
  assign lock_page = lock_addr[12:9];
  assign tgt_page = addr_in[12:9];
  assign pc_page = exec_pc_in[12:9];
  assign tgt_locked = ({4'h0, tgt_page} < locked_pages) ||
    (any_locked && tgt_page == lock_page);
  assign pc_locked = ({4'h0, pc_page} < locked_pages) ||
    (any_locked && pc_page == lock_page);
  assign above_user = (addr_in > {3'h0, `FPEG_USER_LIMIT});
  assign cpu_flash_wr = xmove_write_in && store_write_enable_in;
  assign external_data_ram_select_out = xmove_read_in ||
    (xmove_write_in && !store_write_enable_in);
  assign cpu_stall_out = tmr_busy || op_pending;
  // Software access legality
  assign access_bad = above_user || (tgt_locked && !pc_locked) ||
    (cpu_flash_wr && store_erase_enable_in && tgt_page == lock_page) ||
    (cpu_flash_wr && !store_erase_enable_in &&
     addr_in[12:0] == `FPEG_LOCK_ADDR && lock_taken);
  fpeg_timer u_timer (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .start_in(tmr_start),
    .count_in(tmr_count),
    .busy_out(tmr_busy),
    .done_out(tmr_done)
  );
  // ****************************************
  // Sequencer
  // ****************************************
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      key_state <= `FPEG_LOCK_LOCKED;
      lock_eff <= 8'hFF;
      lock_taken <= 1'b0;
      tmr_start <= 1'b0;
      tmr_count <= 19'h00000;
      op_pending <= 1'b0;
      op_is_prog <= 1'b0;
      dbg_ignored_out <= 1'b0;
      flash_rd_out <= 1'b0;
      flash_prog_out <= 1'b0;
      flash_erase_page_out <= 1'b0;
      flash_erase_all_out <= 1'b0;
      flash_addr_out <= 13'h0000;
      flash_wdata_out <= 8'h00;
      flash_fault_reset_out <= 1'b0;
      flash_fault_reset_flag_out <= fault_seen;
    end else begin
      tmr_start <= 1'b0;
      dbg_ignored_out <= 1'b0;
      flash_rd_out <= 1'b0;
      flash_prog_out <= 1'b0;
      flash_erase_page_out <= 1'b0;
      flash_erase_all_out <= 1'b0;
      flash_fault_reset_out <= 1'b0;
      if (!lock_taken) begin
        lock_eff <= lock_byte_in;
        lock_taken <= 1'b1;
        // Fault memory consumed once the flag has taken it
        fault_seen <= 1'b0;
      end
      if (key_write_in && !cpu_stall_out) begin
        if (key_state == `FPEG_LOCK_LOCKED) begin
          key_state <= (key_data_in == `FPEG_KEY_FIRST) ?
            `FPEG_LOCK_FIRST : `FPEG_LOCK_DEAD;
        end else if (key_state == `FPEG_LOCK_FIRST) begin
          key_state <= (key_data_in == `FPEG_KEY_SECOND) ?
            `FPEG_LOCK_OPEN : `FPEG_LOCK_DEAD;
        end else begin
          key_state <= `FPEG_LOCK_DEAD;
        end
      end else if (cpu_flash_wr && !cpu_stall_out) begin
        if (access_bad) begin
          fault_seen <= 1'b1;
          flash_fault_reset_out <= 1'b1;
        end else if (key_state != `FPEG_LOCK_OPEN) begin
          key_state <= `FPEG_LOCK_DEAD;
        end else begin
          flash_addr_out <= addr_in[12:0];
          op_pending <= 1'b1;
          tmr_start <= 1'b1;
          if (store_erase_enable_in) begin
            flash_erase_page_out <= 1'b1;
            op_is_prog <= 1'b0;
            tmr_count <= erase_cycles[18:0];
            flash_wdata_out <= `FPEG_ERASED_BYTE;
          end else begin
            flash_prog_out <= 1'b1;
            op_is_prog <= 1'b1;
            tmr_count <= write_cycles[18:0];
            flash_wdata_out <= wdata_in & flash_rdata_in;
          end
        end
      end else if (code_read_in && !cpu_stall_out) begin
        if (above_user || (tgt_locked && !pc_locked)) begin
          fault_seen <= 1'b1;
          flash_fault_reset_out <= 1'b1;
        end else begin
          flash_addr_out <= addr_in[12:0];
          flash_rd_out <= 1'b1;
        end
      end else if (dbg_device_erase_in && !cpu_stall_out) begin
        flash_erase_all_out <= 1'b1;
        op_pending <= 1'b1;
        op_is_prog <= 1'b0;
        tmr_start <= 1'b1;
        tmr_count <= erase_cycles[18:0];
      end else if ((dbg_write_in || dbg_page_erase_in || dbg_read_in) &&
                   !cpu_stall_out) begin
        if (above_user || tgt_locked) begin
          dbg_ignored_out <= 1'b1;
        end else begin
          flash_addr_out <= addr_in[12:0];
          flash_rd_out <= dbg_read_in;
          flash_prog_out <= dbg_write_in;
          flash_erase_page_out <= dbg_page_erase_in;
          flash_wdata_out <= wdata_in & flash_rdata_in;
        end
      end
      if (tmr_done) begin
        op_pending <= 1'b0;
        if (key_state == `FPEG_LOCK_OPEN) begin
          key_state <= `FPEG_LOCK_LOCKED;
        end
      end
    end
  end
endmodule // fpeg_guard
`default_nettype wire

// File: fpeg_consts.vh
// Constants for the flash program and erase guard
`ifndef FPEG_CONSTS_VH
`define FPEG_CONSTS_VH
`define FPEG_KEY_FIRST 8'hA5
`define FPEG_KEY_SECOND 8'hF1
`define FPEG_ERASED_BYTE 8'hFF
`define FPEG_USER_LIMIT 13'h1DFF
`define FPEG_RESERVED_BASE 13'h1E00
`define FPEG_LOCK_ADDR 13'h1DFF
`define FPEG_PAGE_BITS 9
`define FPEG_LOCK_LOCKED 2'h0
`define FPEG_LOCK_FIRST 2'h1
`define FPEG_LOCK_OPEN 2'h2
`define FPEG_LOCK_DEAD 2'h3
`define FPEG_CLK_MHZ 25
`define FPEG_ERASE_US 15000
`define FPEG_WRITE_US 55
`define FPEG_ERASE_CYCLES (`FPEG_ERASE_US * `FPEG_CLK_MHZ)
`define FPEG_WRITE_CYCLES (`FPEG_WRITE_US * `FPEG_CLK_MHZ)
`endif

// File: fpeg_timer.v
// Operation timer counting down a busy interval
`timescale 1ns/100ps
`default_nettype none
module fpeg_timer (
  input wire sys_clk_in,
  input wire rst_in,
  input wire start_in,
  input wire [18:0] count_in,
  output reg busy_out,
  output wire done_out
);
  reg [18:0] remain;
  assign done_out = busy_out && (remain == 19'h00001);
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      remain <= 19'h00000;
      busy_out <= 1'b0;
    end else if (start_in && !busy_out) begin
      remain <= count_in;
      busy_out <= 1'b1;
    end else if (busy_out) begin
      remain <= remain - 19'h00001;
      if (remain == 19'h00001) begin
        busy_out <= 1'b0;
      end
    end
  end
endmodule // fpeg_timer
`default_nettype wire

// File: fpeg_chk_asserts.sv
// Checker for the flash program and erase guard
`timescale 1ns/100ps
`default_nettype none
module fpeg_chk (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic key_write_in,
  input wire logic [7:0] key_data_in,
  input wire logic [7:0] flash_key_register_out,
  input wire logic store_write_enable_in,
  input wire logic store_erase_enable_in,
  input wire logic xmove_write_in,
  input wire logic xmove_read_in,
  input wire logic [15:0] addr_in,
  input wire logic cpu_stall_out,
  input wire logic external_data_ram_select_out,
  input wire logic flash_prog_out,
  input wire logic flash_erase_page_out
);
  wire [1:0] st = flash_key_register_out[1:0];
  wire k = key_write_in && !cpu_stall_out;
  wire w = xmove_write_in && store_write_enable_in && !cpu_stall_out &&
    !key_write_in;
  wire ok = addr_in < 16'h1C00;
  wire see = store_erase_enable_in;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  AST_KEY1: assert property (k && key_data_in == 8'hA5 && st == 2'h0 |=> st == 2'h1)
    else $error("first key not taken");
  AST_KEY2: assert property (k && key_data_in == 8'hF1 && st == 2'h1 |=> st == 2'h2)
    else $error("second key not taken");
  AST_BADKEY: assert property (k && st == 2'h0 && key_data_in != 8'hA5 |=> st == 2'h3)
    else $error("bad key not disabling");
  AST_DEAD: assert property (st == 2'h3 |=> st == 2'h3)
    else $error("disable left before reset");
  AST_EARLY: assert property (w && ok && st < 2'h2 |=> st == 2'h3)
    else $error("locked write not disabling");
  AST_PROG: assert property (w && !see && st == 2'h2 && ok |=> flash_prog_out && !flash_erase_page_out)
    else $error("program not issued");
  AST_ERASE: assert property (w && see && st == 2'h2 && ok |=> flash_erase_page_out && !flash_prog_out)
    else $error("erase not issued");
  AST_STALL: assert property (flash_prog_out || flash_erase_page_out |-> ##[0:1] cpu_stall_out)
    else $error("no stall");
  AST_RELOCK: assert property ($fell(cpu_stall_out) |-> ##[0:1] st == 2'h0)
    else $error("not relocked");
  AST_XREAD: assert property (xmove_read_in |-> external_data_ram_select_out)
    else $error("read not to ram");
  AST_XWRITE: assert property (xmove_write_in && store_write_enable_in |-> !external_data_ram_select_out)
    else $error("write not to flash");
  cover property (flash_prog_out);
  cover property (flash_erase_page_out);
  cover property (st == 2'h3);
endmodule // fpeg_chk
bind fpeg_guard fpeg_chk i_fpeg_chk (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
  .key_write_in(key_write_in), .key_data_in(key_data_in),
  .flash_key_register_out(flash_key_register_out), .addr_in(addr_in),
  .store_write_enable_in(store_write_enable_in), .xmove_read_in(xmove_read_in),
  .store_erase_enable_in(store_erase_enable_in), .xmove_write_in(xmove_write_in),
  .cpu_stall_out(cpu_stall_out), .external_data_ram_select_out(external_data_ram_select_out),
  .flash_prog_out(flash_prog_out), .flash_erase_page_out(flash_erase_page_out));
`default_nettype wire

// File: fpeg_cpu_model.sv
// CPU core model issuing key writes and external-move writes
`timescale 1ns/100ps
`default_nettype none
module fpeg_cpu_model (
  input wire logic clk_in,
  output logic kw_out,
  output logic [7:0] kd_out,
  output logic xw_out,
  output logic [15:0] ad_out,
  output logic [7:0] wd_out
);
  initial {kw_out, kd_out, xw_out, ad_out, wd_out} = '0;
  task automatic key_wr(input logic [7:0] d);
    @(posedge clk_in);
    kw_out <= 1'b1;
    kd_out <= d;
    @(posedge clk_in);
    kw_out <= 1'b0;
    kd_out <= ~d;
  endtask
  task automatic unlock;
    key_wr(8'hA5);
    key_wr(8'hF1);
  endtask
  task automatic set_addr(input logic [15:0] a);
    @(posedge clk_in);
    ad_out <= a;
  endtask
  task automatic xwr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    xw_out <= 1'b1;
    ad_out <= a;
    wd_out <= d;
    @(posedge clk_in);
    xw_out <= 1'b0;
    ad_out <= ~a;
    wd_out <= ~d;
  endtask
endmodule // fpeg_cpu_model
`default_nettype wire

// File: tb_top.sv
// Testbench for the flash program and erase guard
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk = 0, rst = 1, swe = 0, see = 0, xrd = 0, dev = 0;
  logic kw, xw, crd = 0, drd = 0;
  logic [7:0] lkb = 8'hFF, rdat = 8'hF0;
  logic [12:0] epc = 13'h0000;
  wire ign, frd;
  logic [7:0] kd, wd;
  logic [15:0] ad;
  wire [7:0] key, fwd;
  wire [12:0] fad;
  wire stall, xsel, fprog, fepg, feall, frst, fflag;
  int num_errors = 0, checks_done = 0, cyc = 0, n;
  initial forever #20 clk = ~clk;
  fpeg_cpu_model i_fpeg_cpu_model (.clk_in(clk), .kw_out(kw), .kd_out(kd),
    .xw_out(xw), .ad_out(ad), .wd_out(wd));
  fpeg_guard i_fpeg_guard (.sys_clk_in(clk), .rst_in(rst), .key_write_in(kw),
    .key_data_in(kd), .flash_key_register_out(key), .store_write_enable_in(swe),
    .store_erase_enable_in(see), .xmove_write_in(xw), .xmove_read_in(xrd),
    .code_read_in(crd), .addr_in(ad), .wdata_in(wd), .exec_pc_in(epc),
    .lock_byte_in(lkb), .flash_rdata_in(rdat), .dbg_write_in(1'b0),
    .dbg_page_erase_in(1'b0), .dbg_device_erase_in(dev), .dbg_read_in(drd),
    .dbg_ignored_out(ign), .cpu_stall_out(stall), .external_data_ram_select_out(xsel),
    .flash_rd_out(frd), .flash_prog_out(fprog), .flash_erase_page_out(fepg),
    .flash_erase_all_out(feall), .flash_addr_out(fad), .flash_wdata_out(fwd),
    .flash_fault_reset_out(frst), .flash_fault_reset_flag_out(fflag));
  task chk(input string s, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  task complete_run;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task reset_dut(input int c);
    @(posedge clk) rst <= 1;
    repeat (c) @(posedge clk);
    rst <= 0;
    @(posedge clk) #1;
  endtask
  task t_prog;
    i_fpeg_cpu_model.unlock;
    #1 chk("key", 16'h0002, key);
    @(posedge clk) swe <= 1;
    i_fpeg_cpu_model.xwr(16'h0123, 8'h5A);
    #1 chk("prog", 16'h0001, fprog);
    chk("addr", 16'h0123, fad);
    chk("wdata", 16'h0050, fwd);
    for (n = 0; n < 2000 && stall; n++) @(posedge clk) #1;
    chk("busy", 16'h0001, n > 1300 && n < 1400);
    chk("relock", 16'h0000, key);
  endtask
  task t_bad;
    i_fpeg_cpu_model.key_wr(8'hF1);
    #1 chk("badkey", 16'h0003, key);
    i_fpeg_cpu_model.unlock;
    i_fpeg_cpu_model.xwr(16'h0200, 8'h00);
    #1 chk("dead", 16'h0003, {fprog, key[1:0]});
    reset_dut(2);
    chk("rekey", 16'h0000, key);
    i_fpeg_cpu_model.xwr(16'h0200, 8'h00);
    #1 chk("early", 16'h0003, {fprog, key[1:0]});
    reset_dut(2);
  endtask
  task t_erase;
    i_fpeg_cpu_model.unlock;
    @(posedge clk) see <= 1;
    i_fpeg_cpu_model.xwr(16'h0345, 8'h12);
    #1 chk("erase", 16'h0002, {fepg, fprog});
    @(posedge clk) #1 chk("stall", 16'h0001, stall);
    see <= 0;
    reset_dut(2);
    chk("idle", 16'h0000, {stall, key});
    @(posedge clk) dev <= 1;
    @(posedge clk) dev <= 0;
    #1 chk("devera", 16'h0001, feall);
    reset_dut(2);
    @(posedge clk) xrd <= 1;
    #1 chk("xread", 16'h0001, xsel);
    @(posedge clk) xrd <= 0;
  endtask
  task t_fault;
    i_fpeg_cpu_model.unlock;
    i_fpeg_cpu_model.xwr(16'h1E10, 8'h00);
    #1 chk("fault", 16'h0001, frst);
    reset_dut(2);
    chk("flag", 16'h0001, fflag);
  endtask
  task t_lock;
    @(posedge clk) lkb <= 8'hFE;
    epc <= 13'h0400;
    reset_dut(2);
    i_fpeg_cpu_model.set_addr(16'h0010);
    @(posedge clk) crd <= 1;
    @(posedge clk) crd <= 0;
    #1 chk("lockflt", 16'h0001, frst);
    @(posedge clk) epc <= 13'h0000;
    reset_dut(2);
    @(posedge clk) crd <= 1;
    @(posedge clk) crd <= 0;
    #1 chk("lockrd", 16'h0002, {frd, frst});
    @(posedge clk) drd <= 1;
    @(posedge clk) drd <= 0;
    #1 chk("dbgign", 16'h0002, {ign, frst});
    @(posedge clk) lkb <= 8'hFF;
    reset_dut(2);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      complete_run;
    end
  end
  initial begin
    reset_dut(12);
    t_prog;
    t_bad;
    t_erase;
    t_fault;
    t_lock;
    complete_run;
  end
endmodule // tb_top
`default_nettype wire
